// File: hdl/port_pin_function_control.sv
// Three-group port block: per-pin direction, pull-up, drive type and
// alternate-function routing, reached over APB with two interrupt events.
// Assumes pin inputs are synchronous to pclk; the pad resolves oe/pu.
//
// Overview of operation
// - Each pin of port b is set input or output by its own direction bit.
// - A pull-up is applied to an input pin when its group's pull-up bit is set.
// - One bit picks push-pull or open drain for all port b outputs together.
// - Port c has seven pins; pins 0, 1, 2 and 6 switch between port mode and their function.
// - In port mode each port c pin takes its direction from its own bit.
// - Only port c pins 5 and 6 may select open drain, each on its own bit.
// - Control mode routes serial data in, data out and a two-way clock.
// - Control mode feeds the timer clock from its pin and drives timer out.
// - The interrupt pin raises events on rising, falling or both edges.
// - Port d has eight pins, each switchable between port and key-return mode.
// - In port mode port d pins follow their direction bits, with pull-ups.
// - In control mode port d pins are active-low key-return inputs.
// - The active-low reset returns all port logic to its initial state.
`timescale 1ns/1ps
module port_pin_function_control #(
  parameter int ADDR_W = port_pkg::ADDR_W
) (
  // APB slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Port b pins
  input  wire logic [7:0]        port_b_in,
  output logic [7:0]             port_b_out,
  output logic [7:0]             port_b_oe,
  output logic [7:0]             port_b_pu,
  // Port c pins
  input  wire logic [6:0]        port_c_in,
  output logic [6:0]             port_c_out,
  output logic [6:0]             port_c_oe,
  output logic [6:0]             port_c_pu,
  // Port d pins
  input  wire logic [7:0]        port_d_in,
  output logic [7:0]             port_d_out,
  output logic [7:0]             port_d_oe,
  output logic [7:0]             port_d_pu,
  // Serial interface side
  input  wire logic              serial_clock_out,
  input  wire logic              serial_data_out,
  output logic                   serial_clock_in,
  output logic                   serial_data_in,
  // Timer side
  input  wire logic              timer_out,
  output logic                   timer_ext_clock_in,
  // Events
  output logic                   ext_irq_event,
  output logic                   key_return_event,
  output logic                   irq
);
  import port_pkg::*;

  initial begin
    if (ADDR_W < 7 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 7 and 32");
    end
  end

  logic [7:0] port_b_latch_ff;
  logic [7:0] port_b_direction_reg;
  logic [6:0] port_c_latch_ff;
  logic [6:0] port_c_direction_reg;
  logic [6:0] port_c_mode_ff;
  logic [7:0] port_d_latch_ff;
  logic [7:0] port_d_direction_reg;
  logic [7:0] port_d_mode_ff;
  logic [2:0] pullup_option_reg;
  logic       drive_type_reg_a;
  logic [6:0] drive_type_reg_b;
  edge_sel_t  edge_sel_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic [7:0] b_in_ff;
  logic [6:0] c_in_ff;
  logic [7:0] d_in_ff;

  logic       setup;
  logic       wr_en;
  logic [7:0] addr;
  logic [31:0] nxt_prdata;
  logic       nxt_slverr;
  logic       ext_hit;
  logic       key_hit;
  logic       key_level;
  logic [1:0] nxt_stat;

  pin_cfg_t   cfg_b [B_W];
  pin_cfg_t   cfg_c [C_W];
  pin_cfg_t   cfg_d [D_W];
  pin_drive_t drv_b [B_W];
  pin_drive_t drv_c [C_W];
  pin_drive_t drv_d [D_W];

  assign addr  = 8'(paddr);
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // No wait state: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && nxt_slverr;
      if (setup && !pwrite) begin
        prdata <= nxt_prdata;
      end
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    case (addr)
      OFS_B_OUT:  nxt_prdata[7:0] = port_b_latch_ff;
      OFS_B_DIR:  nxt_prdata[7:0] = port_b_direction_reg;
      OFS_C_OUT:  nxt_prdata[6:0] = port_c_latch_ff;
      OFS_C_DIR:  nxt_prdata[6:0] = port_c_direction_reg;
      OFS_C_MODE: nxt_prdata[6:0] = port_c_mode_ff;
      OFS_D_OUT:  nxt_prdata[7:0] = port_d_latch_ff;
      OFS_D_DIR:  nxt_prdata[7:0] = port_d_direction_reg;
      OFS_D_MODE: nxt_prdata[7:0] = port_d_mode_ff;
      OFS_PULLUP: nxt_prdata[2:0] = pullup_option_reg;
      OFS_DRV_A:  nxt_prdata[OD_A_BIT] = drive_type_reg_a;
      OFS_DRV_B:  nxt_prdata[6:0] = drive_type_reg_b;
      OFS_EDGE:   nxt_prdata[1:0] = edge_sel_ff;
      OFS_STAT:   nxt_prdata[1:0] = stat_ff;
      OFS_MASK:   nxt_prdata[1:0] = mask_ff;
      OFS_B_IN:   nxt_prdata[7:0] = b_in_ff;
      OFS_C_IN:   nxt_prdata[6:0] = c_in_ff;
      OFS_D_IN:   nxt_prdata[7:0] = d_in_ff;
      default:    nxt_slverr = 1'b1;
    endcase
  end

  // Port b configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_latch_ff      <= 8'h00;
      port_b_direction_reg <= DIR_B_RST;
      drive_type_reg_a     <= 1'b0;
    end else if (wr_en) begin
      case (addr)
        OFS_B_OUT: port_b_latch_ff <= pwdata[7:0];
        OFS_B_DIR: port_b_direction_reg <= pwdata[7:0];
        OFS_DRV_A: drive_type_reg_a <= pwdata[OD_A_BIT];
        default: ;
      endcase
    end
  end

  // Port c configuration; mode bits exist only where a function does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_latch_ff      <= 7'h00;
      port_c_direction_reg <= DIR_C_RST;
      port_c_mode_ff       <= 7'h00;
      drive_type_reg_b     <= 7'h00;
    end else if (wr_en) begin
      case (addr)
        OFS_C_OUT:  port_c_latch_ff <= pwdata[6:0];
        OFS_C_DIR:  port_c_direction_reg <= pwdata[6:0];
        OFS_C_MODE: port_c_mode_ff <= pwdata[6:0] & MODE_C_MASK;
        OFS_DRV_B:  drive_type_reg_b <= pwdata[6:0] & DRV_B_MASK;
        default: ;
      endcase
    end
  end

  // Port d configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_d_latch_ff      <= 8'h00;
      port_d_direction_reg <= DIR_D_RST;
      port_d_mode_ff       <= 8'h00;
    end else if (wr_en) begin
      case (addr)
        OFS_D_OUT:  port_d_latch_ff <= pwdata[7:0];
        OFS_D_DIR:  port_d_direction_reg <= pwdata[7:0];
        OFS_D_MODE: port_d_mode_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Shared options
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_option_reg <= 3'h0;
      edge_sel_ff       <= EDGE_NONE;
      mask_ff           <= 2'h0;
    end else if (wr_en) begin
      case (addr)
        OFS_PULLUP: pullup_option_reg <= pwdata[2:0];
        OFS_EDGE:   edge_sel_ff <= edge_sel_t'(pwdata[1:0]);
        OFS_MASK:   mask_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Pin input sampling, read back by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {b_in_ff, c_in_ff, d_in_ff} <= '1;
    end else begin
      {b_in_ff, c_in_ff, d_in_ff} <= {port_b_in, port_c_in, port_d_in};
    end
  end

  // Per-pin configuration; software owns direction for serial pins
  always_comb begin
    for (int i = 0; i < B_W; i++) begin
      cfg_b[i].ctrl   = 1'b0;
      cfg_b[i].dir_in = port_b_direction_reg[i];
      cfg_b[i].od     = drive_type_reg_a;
      cfg_b[i].pu     = pullup_option_reg[PU_B_BIT];
      cfg_b[i].latch  = port_b_latch_ff[i];
      cfg_b[i].periph = 1'b0;
    end
    for (int i = 0; i < C_W; i++) begin
      cfg_c[i].ctrl   = port_c_mode_ff[i];
      cfg_c[i].dir_in = port_c_direction_reg[i];
      cfg_c[i].od     = drive_type_reg_b[i];
      cfg_c[i].pu     = pullup_option_reg[PU_C_BIT];
      cfg_c[i].latch  = port_c_latch_ff[i];
      cfg_c[i].periph = 1'b0;
    end
    cfg_c[C_SCLK].periph  = serial_clock_out;
    cfg_c[C_SDO].periph   = serial_data_out;
    cfg_c[C_MULTI].periph = timer_out;
    for (int i = 0; i < D_W; i++) begin
      cfg_d[i].ctrl   = port_d_mode_ff[i];
      // Key-return pins never drive
      cfg_d[i].dir_in = port_d_direction_reg[i] || port_d_mode_ff[i];
      cfg_d[i].od     = 1'b0;
      cfg_d[i].pu     = pullup_option_reg[PU_D_BIT];
      cfg_d[i].latch  = port_d_latch_ff[i];
      cfg_d[i].periph = 1'b0;
    end
  end

  for (genvar i = 0; i < B_W; i++) begin : g_b
    pin_cell u_cell (.cfg (cfg_b[i]), .drv (drv_b[i]));
  end
  for (genvar i = 0; i < C_W; i++) begin : g_c
    pin_cell u_cell (.cfg (cfg_c[i]), .drv (drv_c[i]));
  end
  for (genvar i = 0; i < D_W; i++) begin : g_d
    pin_cell u_cell (.cfg (cfg_d[i]), .drv (drv_d[i]));
  end

  // Registered pad drive; one cycle after a register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {port_b_out, port_b_oe, port_b_pu, port_c_out, port_c_oe, port_c_pu} <= '0;
      {port_d_out, port_d_oe, port_d_pu} <= '0;
    end else begin
      for (int i = 0; i < B_W; i++) begin
        port_b_out[i] <= drv_b[i].out;
        port_b_oe[i]  <= drv_b[i].oe;
        port_b_pu[i]  <= drv_b[i].pu;
      end
      for (int i = 0; i < C_W; i++) begin
        port_c_out[i] <= drv_c[i].out;
        port_c_oe[i]  <= drv_c[i].oe;
        port_c_pu[i]  <= drv_c[i].pu;
      end
      for (int i = 0; i < D_W; i++) begin
        port_d_out[i] <= drv_d[i].out;
        port_d_oe[i]  <= drv_d[i].oe;
        port_d_pu[i]  <= drv_d[i].pu;
      end
    end
  end

  // Serial inputs idle high and the timer clock input idles low outside control mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {serial_clock_in, serial_data_in, timer_ext_clock_in} <= 3'h6;
    end else begin
      serial_clock_in    <= c_in_ff[C_SCLK] || !port_c_mode_ff[C_SCLK];
      serial_data_in     <= c_in_ff[C_SDI] || !port_c_mode_ff[C_SDI];
      timer_ext_clock_in <= c_in_ff[C_MULTI] && port_c_mode_ff[C_MULTI];
    end
  end

  // Low while any key-return pin is pulled low
  assign key_level = &(d_in_ff | ~port_d_mode_ff);
  edge_detect u_ext_edge (
    .clk   (pclk),
    .rst_n (presetn),
    .sig   (c_in_ff[C_MULTI] || !port_c_mode_ff[C_MULTI]),
    .sel   (edge_sel_ff),
    .hit   (ext_hit)
  );
  edge_detect u_key_edge (
    .clk   (pclk),
    .rst_n (presetn),
    .sig   (key_level),
    .sel   (EDGE_FALL),
    .hit   (key_hit)
  );
  // Sticky status; a new event wins over a same-cycle clear
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_en && addr == OFS_STAT) begin
      nxt_stat = stat_ff & ~pwdata[1:0];
    end
    nxt_stat[ST_EXT_BIT] = nxt_stat[ST_EXT_BIT] || ext_hit;
    nxt_stat[ST_KEY_BIT] = nxt_stat[ST_KEY_BIT] || key_hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {stat_ff, irq, ext_irq_event, key_return_event} <= '0;
    end else begin
      stat_ff          <= nxt_stat;
      irq              <= |(nxt_stat & mask_ff);
      ext_irq_event    <= ext_hit;
      key_return_event <= key_hit;
    end
  end
endmodule

// File: hdl/port_pkg.sv
// Constants, register map and carrier types of the pin-function block.
// Assumes a 32-bit APB register bus with byte addresses in the low bits.
package port_pkg;
  // Port widths
  localparam int B_W = 8;
  localparam int C_W = 7;
  localparam int D_W = 8;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_B_OUT  = 8'h00;
  localparam logic [7:0] OFS_B_DIR  = 8'h04;
  localparam logic [7:0] OFS_C_OUT  = 8'h08;
  localparam logic [7:0] OFS_C_DIR  = 8'h0C;
  localparam logic [7:0] OFS_C_MODE = 8'h10;
  localparam logic [7:0] OFS_D_OUT  = 8'h14;
  localparam logic [7:0] OFS_D_DIR  = 8'h18;
  localparam logic [7:0] OFS_D_MODE = 8'h1C;
  localparam logic [7:0] OFS_PULLUP = 8'h20;
  localparam logic [7:0] OFS_DRV_A  = 8'h24;
  localparam logic [7:0] OFS_DRV_B  = 8'h28;
  localparam logic [7:0] OFS_EDGE   = 8'h2C;
  localparam logic [7:0] OFS_STAT   = 8'h30;
  localparam logic [7:0] OFS_MASK   = 8'h34;
  localparam logic [7:0] OFS_B_IN   = 8'h38;
  localparam logic [7:0] OFS_C_IN   = 8'h3C;
  localparam logic [7:0] OFS_D_IN   = 8'h40;
  // Reset values: every pin an input, port mode
  localparam logic [7:0] DIR_B_RST  = 8'hFF;
  localparam logic [6:0] DIR_C_RST  = 7'h7F;
  localparam logic [7:0] DIR_D_RST  = 8'hFF;
  // Port c pins that own an alternate function; port c pins that may select open drain
  localparam logic [6:0] MODE_C_MASK = 7'h47;
  localparam logic [6:0] DRV_B_MASK  = 7'h60;
  // Field positions
  localparam int PU_B_BIT = 0;
  localparam int PU_C_BIT = 1;
  localparam int PU_D_BIT = 2;
  localparam int OD_A_BIT = 0;
  localparam int ST_EXT_BIT = 0;
  localparam int ST_KEY_BIT = 1;
  localparam int C_SCLK = 0;
  localparam int C_SDO  = 1;
  localparam int C_SDI  = 2;
  localparam int C_MULTI = 6;

  typedef enum logic [1:0] {
    EDGE_NONE,
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH
  } edge_sel_t;

  typedef struct packed {
    logic ctrl;
    logic dir_in;
    logic od;
    logic pu;
    logic latch;
    logic periph;
  } pin_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } pin_drive_t;
endpackage

// File: hdl/pin_cell.sv
// One pin's drive logic: output source, enable, open drain, pull-up.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module pin_cell (
  // Configuration
  input  port_pkg::pin_cfg_t   cfg,
  // Pin drive
  output port_pkg::pin_drive_t drv
);
  import port_pkg::*;

  logic val;

  always_comb begin
    val = cfg.ctrl ? cfg.periph : cfg.latch;
    drv.out = val;
    // Open drain only pulls low, never drives high
    drv.oe = !cfg.dir_in && (!cfg.od || !val);
    drv.pu = cfg.pu && cfg.dir_in;
  end
endmodule

// File: hdl/edge_detect.sv
// Edge detector with selectable edge and a registered one-cycle hit.
// Input is taken as synchronous to clk.
`timescale 1ns/1ps
module edge_detect (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Sampled level and edge choice
  input  wire logic               sig,
  input  port_pkg::edge_sel_t     sel,
  // Event
  output logic                    hit
);
  import port_pkg::*;

  logic prev_ff;
  logic rise;
  logic fall;

  assign rise = sig && !prev_ff;
  assign fall = !sig && prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= sig;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      case (sel)
        EDGE_RISE: hit <= rise;
        EDGE_FALL: hit <= fall;
        EDGE_BOTH: hit <= rise || fall;
        default:   hit <= 1'b0;
      endcase
    end
  end
endmodule

// File: testbench/port_pin_function_control_props.sv
// Checker of pin drive, event causes and bus answer timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module port_pin_function_control_props
  import port_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic [7:0]  port_b_oe,
  input wire logic [7:0]  port_b_pu,
  input wire logic [6:0]  port_c_in,
  input wire logic [6:0]  port_c_oe,
  input wire logic [6:0]  port_c_pu,
  input wire logic [7:0]  port_d_in,
  input wire logic [7:0]  port_d_oe,
  input wire logic [7:0]  port_d_pu,
  // Peripheral side and events
  input wire logic        serial_data_in,
  input wire logic        ext_irq_event,
  input wire logic        key_return_event,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire wacc  = psel && penable && pwrite;
  apb_one_wait_a: assert property (setup |=> pready && !$past(pready))
    else $error("pready not one cycle after setup");
  b_pu_input_a: assert property ((port_b_pu & port_b_oe) == 8'h00)
    else $error("pull-up on a driven port b pin");
  c_pu_input_a: assert property ((port_c_pu & port_c_oe) == 7'h00)
    else $error("pull-up on a driven port c pin");
  d_pu_input_a: assert property ((port_d_pu & port_d_oe) == 8'h00)
    else $error("pull-up on a driven port d pin");
  reset_no_drive_a: assert property ($rose(presetn) |->
    (port_b_oe | {port_c_oe, 1'b0} | port_d_oe) == 8'h00)
    else $error("pin driven right after reset");
  ext_edge_cause_a: assert property (ext_irq_event |->
    $past(port_c_in[C_MULTI], 3) != $past(port_c_in[C_MULTI], 4))
    else $error("interrupt event without pin edge");
  key_fall_cause_a: assert property (key_return_event |->
    ($past(port_d_in, 2) != 8'hFF) || ($past(port_d_in, 3) != 8'hFF))
    else $error("key event without a low pin");
  key_pulse_a: assert property (key_return_event |=> !key_return_event)
    else $error("key event longer than one cycle");
  irq_cause_a: assert property ($rose(irq) |->
    ext_irq_event || key_return_event || $past(wacc) || $past(wacc, 2))
    else $error("irq rose without cause");
  sdi_follow_a: assert property (!serial_data_in |->
    !$past(port_c_in[C_SDI]) || !$past(port_c_in[C_SDI], 2))
    else $error("serial data in low without low pin");
  ext_seen_c: cover property (ext_irq_event);
  key_seen_c: cover property (key_return_event);
  irq_seen_c: cover property (irq);
  err_seen_c: cover property (pready && pslverr);
endmodule
bind port_pin_function_control port_pin_function_control_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .port_b_oe(port_b_oe), .port_b_pu(port_b_pu), .port_c_in(port_c_in),
  .port_c_oe(port_c_oe), .port_c_pu(port_c_pu), .port_d_in(port_d_in),
  .port_d_oe(port_d_oe), .port_d_pu(port_d_pu),
  .serial_data_in(serial_data_in), .ext_irq_event(ext_irq_event),
  .key_return_event(key_return_event), .irq(irq));

// File: testbench/pin_world.sv
// Pad model of one pin group: block drive, outside sources, pull-ups.
// Assumes block outputs settle after the clock edge.
`timescale 1ns/1ps
module pin_world #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clk,
  // Block side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  // Outside sources
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  // Resolved level
  output logic [W-1:0]      lvl
);
  logic [W-1:0] float_ff = '0;
  // Floating pins must not read as a stable value
  always_ff @(posedge clk) float_ff <= ~float_ff;
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pu[i]) lvl[i] = 1'b1;
      else lvl[i] = float_ff[i];
    end
  end
endmodule

// File: testbench/test_port_pin_function_control.sv
// Bench of the port block: APB master, pad models, self-checks.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module test_port_pin_function_control;
  import port_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, b_in, b_out, b_oe, b_pu, d_in, d_out, d_oe, d_pu;
  logic [31:0] pwdata = '0, prdata, rd, r, seed = 32'h00000DF9;
  logic [7:0] ext_d = 8'hFF, lat, dir, ext_be = 8'h00, ext_b = 8'h00;
  logic [6:0] c_in, c_out, c_oe, c_pu, ext_c = '0, ext_ce = 7'h7F;
  logic sco = 0, sdo = 0, tmo = 0, sci, sdi, tci, evx, evk, irq, pready, pslverr, err, od, pu;
  int fail_count = 0, comparisons = 0, ev_n = 0, kr_n = 0, ev0 = 0, kr0 = 0;
  always #2 pclk = ~pclk;
  pin_world #(.W(8)) pb (.clk(pclk), .out(b_out), .oe(b_oe), .pu(b_pu),
    .ext_en(ext_be), .ext_val(ext_b), .lvl(b_in));
  pin_world #(.W(7)) pc (.clk(pclk), .out(c_out), .oe(c_oe), .pu(c_pu),
    .ext_en(ext_ce), .ext_val(ext_c), .lvl(c_in));
  pin_world #(.W(8)) pd (.clk(pclk), .out(d_out), .oe(d_oe), .pu(d_pu),
    .ext_en(8'hFF), .ext_val(ext_d), .lvl(d_in));
  port_pin_function_control uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_b_in(b_in), .port_b_out(b_out), .port_b_oe(b_oe), .port_b_pu(b_pu),
    .port_c_in(c_in), .port_c_out(c_out), .port_c_oe(c_oe), .port_c_pu(c_pu),
    .port_d_in(d_in), .port_d_out(d_out), .port_d_oe(d_oe), .port_d_pu(d_pu),
    .serial_clock_out(sco), .serial_data_out(sdo), .serial_clock_in(sci),
    .serial_data_in(sdi), .timer_out(tmo), .timer_ext_clock_in(tci),
    .ext_irq_event(evx), .key_return_event(evk), .irq(irq));
  always @(posedge pclk) begin
    if (evx === 1'b1) ev_n++;
    if (evk === 1'b1) kr_n++;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] oe_exp(logic [7:0] dr, logic [7:0] lt, logic o);
    return ~dr & (o ? ~lt : 8'hFF);
  endfunction
  function automatic int edges(int s);
    return (s == EDGE_BOTH) ? 2 : (s == EDGE_NONE) ? 0 : 1;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    tick(12);
    presetn <= 1'b1;
    tick(1);
    chk({b_oe, c_oe, d_oe, b_pu}, 32'h0);
    rc(OFS_B_DIR, DIR_B_RST);
    rc(OFS_C_DIR, DIR_C_RST);
    rc(OFS_D_DIR, DIR_D_RST);
    apb(1'b0, 8'h44, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      lat = r[7:0];
      dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : r[15:8];
      od = r[16];
      pu = r[17];
      wr(OFS_B_OUT, lat);
      wr(OFS_B_DIR, dir);
      wr(OFS_DRV_A, od);
      wr(OFS_PULLUP, pu);
      tick(3);
      chk(b_oe, oe_exp(dir, lat, od));
      chk(b_pu, pu ? dir : 8'h00);
      if (!od) chk(b_out, lat);
      if (pu && !od) rc(OFS_B_IN, dir | lat);
    end
    wr(OFS_C_MODE, 32'h7F);
    rc(OFS_C_MODE, MODE_C_MASK);
    wr(OFS_DRV_B, 32'h7F);
    rc(OFS_DRV_B, DRV_B_MASK);
    wr(OFS_DRV_B, 32'h0);
    wr(OFS_C_DIR, 32'h3C);
    for (int i = 0; i < 6; i++) begin
      r = xs();
      sco <= r[0];
      sdo <= r[1];
      tmo <= r[2];
      ext_c[C_SDI] <= r[3];
      tick(4);
      chk({c_oe[6], c_oe[1:0]}, 3'h7);
      chk({c_out[6], c_out[1:0], sdi}, {r[2], r[1], r[0], r[3]});
      chk(sci, r[0]);
    end
    wr(OFS_C_MODE, 32'h0);
    wr(OFS_C_DIR, 32'h1F);
    wr(OFS_C_OUT, 32'h60);
    wr(OFS_DRV_B, 32'h40);
    tick(3);
    chk({c_oe[6:5], c_out[5]}, 3'h3);
    wr(OFS_C_MODE, 32'h40);
    wr(OFS_C_DIR, 32'h7F);
    wr(OFS_MASK, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_EDGE, s);
      tick(4);
      ev0 = ev_n;
      ext_c[C_MULTI] <= 1'b1;
      tick(6);
      chk(tci, 1'b1);
      ext_c[C_MULTI] <= 1'b0;
      tick(6);
      chk(ev_n - ev0, edges(s));
    end
    rc(OFS_STAT, 32'h1);
    chk(irq, 1'b0);
    wr(OFS_MASK, 32'h3);
    tick(3);
    chk(irq, 1'b1);
    wr(OFS_STAT, 32'h1);
    tick(3);
    chk(irq, 1'b0);
    wr(OFS_D_MODE, 32'hFF);
    wr(OFS_D_DIR, 32'h0);
    wr(OFS_PULLUP, 32'h6);
    tick(3);
    chk(d_oe, 8'h00);
    chk(c_pu, 7'h7F);
    kr0 = kr_n;
    ext_d[3] <= 1'b0;
    tick(6);
    chk(kr_n - kr0, 32'h1);
    chk(irq, 1'b1);
    rc(OFS_STAT, 32'h2);
    wr(OFS_D_OUT, 32'hA5);
    wr(OFS_D_MODE, 32'h0F);
    tick(3);
    chk({d_oe, d_pu[7:4]}, 12'hF00);
    chk(d_out, 8'hA0);
    wr(OFS_D_DIR, 32'hF0);
    tick(3);
    chk({d_oe, d_pu[7:4]}, 12'h00F);
    wrap_up();
  end
endmodule
